// File: shared/wer_pkg.sv
// package of offsets, reset values and types for the wake event route masks
`default_nettype none
package wer_pkg;
  // ***********************************************************
  // register indices (byte address is four times the index)
  // ***********************************************************
  localparam logic [5:0] WER_IDX_STANDBY_LEGACY = 6'h19;
  localparam logic [5:0] WER_IDX_STANDBY_GENERAL = 6'h1A;
  localparam logic [5:0] WER_IDX_BUTTON_LEGACY = 6'h1B;
  localparam logic [5:0] WER_IDX_BUTTON_GENERAL = 6'h1C;
  localparam logic [5:0] WER_IDX_CONTROL = 6'h1D;
  localparam logic [5:0] WER_IDX_STATUS = 6'h1E;
  // ***********************************************************
  // reset values and field positions
  // ***********************************************************
  localparam logic [4:0] WER_RST_STANDBY_LEGACY = 5'h1F;
  localparam logic [7:0] WER_RST_STANDBY_GENERAL = 8'hFF;
  localparam logic [4:0] WER_RST_BUTTON_LEGACY = 5'h00;
  localparam logic [7:0] WER_RST_BUTTON_GENERAL = 8'h00;
  localparam int WER_CTRL_SOFT_RESET_BIT = 0;
  localparam int WER_STAT_SUPPLY_BIT = 16;
  localparam int WER_STAT_GENERAL_LSB = 8;
  localparam int WER_LEGACY_W = 5;
  localparam int WER_GENERAL_W = 8;
  localparam int WER_SYNC_W = 14;
  // ***********************************************************
  // bus answers
  // ***********************************************************
  localparam logic [1:0] WER_RESP_OKAY = 2'h0;
  localparam logic [1:0] WER_RESP_SLVERR = 2'h2;
  // ***********************************************************
  // types
  // ***********************************************************
  // legacy: 4 consumer_infrared_event, 3 mouse, 2 keyboard_event,
  // 1 ring_indicator_two, 0 ring_indicator_one
  typedef struct packed {
    logic [7:0] general;
    logic [4:0] legacy;
  } wer_events_s;
endpackage
`default_nettype wire

// File: src/wer_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module wer_sync #(
  parameter int WIDTH = 14
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ***********************************************************
  // flop chain
  // ***********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce) begin
      stage1 <= d;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ***********************************************************
  // accept a change once stages two and three agree
  // ***********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          q[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: src/wer_route_masks.sv
// wake event route masks: axi4-lite register bank and event gating
// Operation
// - the standby legacy-source mask loads 1Fh on power-up or software reset.
// - with main supply absent, legacy events reach detectors only where the mask bit is 1.
// - the standby general-input mask loads FFh on power-up or software reset.
// - with main supply absent, general input n reaches its detector only if mask bit n is 1.
// - both button masks clear to 00h on power-up or software reset.
// - legacy events reach the button pulse generator only where the enable bit is 1.
// - general inputs reach the button pulse generator only where the second mask bit is 1.
// - with main supply present, the separate present-supply mask pair replaces the standby masks for detectors; button masks still apply.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module wer_route_masks
  import wer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire wer_events_s raw_events,
  input  wire logic        main_supply_present,
  input  wire wer_events_s present_route_masks,
  output var  wer_events_s detector_events,
  output var  wer_events_s button_events
);
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic [5:0]  wr_idx;
  logic        soft_reset;
  logic [4:0]  standby_route_legacy_sources;
  logic [7:0]  standby_route_general_inputs;
  logic [4:0]  button_route_legacy_sources;
  logic [7:0]  button_route_general_inputs;
  logic [13:0] sync_q;
  wer_events_s events_s;
  logic        supply_s;

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx >= WER_IDX_STANDBY_LEGACY) && (idx <= WER_IDX_STATUS);
  endfunction

  function automatic wer_events_s gate(input wer_events_s ev, input wer_events_s en);
    return ev & en;
  endfunction

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  wer_sync #(
    .WIDTH(WER_SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst  (rst),
    .ce   (ce),
    .d    ({main_supply_present, raw_events}),
    .q    (sync_q)
  );

  assign events_s = sync_q[12:0];
  assign supply_s = sync_q[13];

  // ***********************************************************
  // write channel
  // ***********************************************************
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_idx   = reg_index(aw_addr_q);
  assign soft_reset = do_write && (wr_idx == WER_IDX_CONTROL) && w_strb_q[0]
                      && w_data_q[WER_CTRL_SOFT_RESET_BIT];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= WER_RESP_OKAY;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h00000000;
      w_strb_q      <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(wr_idx) ? WER_RESP_OKAY : WER_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // mask registers
  // ***********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      standby_route_legacy_sources <= WER_RST_STANDBY_LEGACY;
      standby_route_general_inputs <= WER_RST_STANDBY_GENERAL;
      button_route_legacy_sources  <= WER_RST_BUTTON_LEGACY;
      button_route_general_inputs  <= WER_RST_BUTTON_GENERAL;
    end else if (ce) begin
      if (soft_reset) begin
        standby_route_legacy_sources <= WER_RST_STANDBY_LEGACY;
        standby_route_general_inputs <= WER_RST_STANDBY_GENERAL;
        button_route_legacy_sources  <= WER_RST_BUTTON_LEGACY;
        button_route_general_inputs  <= WER_RST_BUTTON_GENERAL;
      end else if (do_write && w_strb_q[0]) begin
        case (wr_idx)
          WER_IDX_STANDBY_LEGACY:  standby_route_legacy_sources <= w_data_q[4:0];
          WER_IDX_STANDBY_GENERAL: standby_route_general_inputs <= w_data_q[7:0];
          WER_IDX_BUTTON_LEGACY:   button_route_legacy_sources  <= w_data_q[4:0];
          WER_IDX_BUTTON_GENERAL:  button_route_general_inputs  <= w_data_q[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // read channel
  // ***********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= WER_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= is_mapped(reg_index(s_axi_araddr)) ? WER_RESP_OKAY
                                                            : WER_RESP_SLVERR;
        case (reg_index(s_axi_araddr))
          WER_IDX_STANDBY_LEGACY:  s_axi_rdata <= {27'h0000000, standby_route_legacy_sources};
          WER_IDX_STANDBY_GENERAL: s_axi_rdata <= {24'h000000, standby_route_general_inputs};
          WER_IDX_BUTTON_LEGACY:   s_axi_rdata <= {27'h0000000, button_route_legacy_sources};
          WER_IDX_BUTTON_GENERAL:  s_axi_rdata <= {24'h000000, button_route_general_inputs};
          WER_IDX_STATUS: begin
            s_axi_rdata <= {15'h0000, supply_s, events_s.general, 3'h0, events_s.legacy};
          end
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // event routing
  // ***********************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      detector_events <= '0;
      button_events   <= '0;
    end else if (ce) begin
      if (supply_s) begin
        detector_events <= gate(events_s, present_route_masks);
      end else begin
        detector_events.legacy  <= events_s.legacy & standby_route_legacy_sources;
        detector_events.general <= events_s.general & standby_route_general_inputs;
      end
      button_events.legacy  <= events_s.legacy & button_route_legacy_sources;
      button_events.general <= events_s.general & button_route_general_inputs;
    end
  end
endmodule
`default_nettype wire

// File: sim/wer_route_masks_chk.sv
// assertion checker for the wake event route masks
`timescale 1ns/100ps
`default_nettype none
module wer_route_masks_chk
  import wer_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire wer_events_s raw_events,
  input  wire wer_events_s detector_events,
  input  wire wer_events_s button_events
);
  // ***********************************************************
  // properties
  // ***********************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  AST_R_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during answer");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == WER_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("refused read not zero");
  AST_DET_GATE: assert property ((detector_events & ~$past(raw_events, 5)) == 13'h0)
    else $error("detector event without source");
  AST_BTN_GATE: assert property ((button_events & ~$past(raw_events, 5)) == 13'h0)
    else $error("button event without source");
endmodule
bind wer_route_masks wer_route_masks_chk i_chk (.clock, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_events,
  .detector_events, .button_events);
`default_nettype wire

// File: sim/wer_wake_src.sv
// model of the raw wake-up source pins beside the mask block
`timescale 1ns/100ps
`default_nettype none
module wer_wake_src
  import wer_pkg::*;
(
  input  wire wer_events_s want_events,
  input  wire logic        want_supply,
  output var  wer_events_s raw_events,
  output var  logic        main_supply_present
);
  // ***********************************************************
  // pin levels
  // ***********************************************************
  always_comb raw_events = want_events;
  always_comb main_supply_present = want_supply;
endmodule
`default_nettype wire

// File: sim/wer_route_masks_bench.sv
// self-checking bench of the wake event route masks
`timescale 1ns/100ps
`default_nettype none
module wer_route_masks_bench;
  import wer_pkg::*;
  logic        clock, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, main_supply_present, want_supply;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wer_events_s raw_events, present_route_masks, detector_events, button_events, want_events;
  int          miscompares, tests_run;
  wer_route_masks i_wer_route_masks (.clock, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_events, .main_supply_present,
    .present_route_masks, .detector_events, .button_events);
  wer_wake_src i_wer_wake_src (.want_events, .want_supply, .raw_events, .main_supply_present);
  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge clock);
      if (!ta && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
      if (!tw && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    cmp({30'h0, s_axi_bresp}, {30'h0, r});
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clock); while (!s_axi_rvalid);
    cmp(s_axi_rdata, e);
    cmp({30'h0, s_axi_rresp}, {30'h0, r});
    s_axi_rready <= 0;
  endtask
  task automatic ev(input logic [12:0] raw, input logic sup, input logic [12:0] dm, bm);
    want_events <= raw; want_supply <= sup;
    repeat (8) @(posedge clock);
    cmp({19'h0, detector_events}, {19'h0, raw & dm});
    cmp({19'h0, button_events}, {19'h0, raw & bm});
  endtask
  task automatic defaults;
    rd(8'h64, 32'h1F, WER_RESP_OKAY);
    rd(8'h68, 32'hFF, WER_RESP_OKAY);
    rd(8'h6C, 32'h0, WER_RESP_OKAY);
    rd(8'h70, 32'h0, WER_RESP_OKAY);
  endtask
  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset;
    defaults();
    rd(8'h00, 32'h0, WER_RESP_SLVERR);
    ev(13'h1FFF, 0, 13'h1FFF, 13'h0);
    $display("test reset values done");
  endtask
  task automatic t_standby;
    wr(8'h64, 32'hEA, WER_RESP_OKAY);
    wr(8'h68, 32'h5A, WER_RESP_OKAY);
    wr(8'h6C, 32'h15, WER_RESP_OKAY);
    wr(8'h70, 32'hA5, WER_RESP_OKAY);
    rd(8'h64, 32'h0A, WER_RESP_OKAY);
    rd(8'h70, 32'hA5, WER_RESP_OKAY);
    ev(13'h1FFF, 0, {8'h5A, 5'h0A}, {8'hA5, 5'h15});
    ev({8'h0F, 5'h13}, 0, {8'h5A, 5'h0A}, {8'hA5, 5'h15});
    rd(8'h78, 32'h00000F13, WER_RESP_OKAY);
    $display("test standby and button routing done");
  endtask
  task automatic t_present;
    present_route_masks <= {8'h3C, 5'h11};
    ev(13'h1FFF, 1, {8'h3C, 5'h11}, {8'hA5, 5'h15});
    rd(8'h78, 32'h0001FF1F, WER_RESP_OKAY);
    ev(13'h1FFF, 0, {8'h5A, 5'h0A}, {8'hA5, 5'h15});
    $display("test supply present done");
  endtask
  task automatic t_soft;
    wr(8'h74, 32'h1, WER_RESP_OKAY);
    defaults();
    s_axi_wstrb <= 4'h0;
    wr(8'h68, 32'h00, WER_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(8'h68, 32'hFF, WER_RESP_OKAY);
    wr(8'h80, 32'h55, WER_RESP_SLVERR);
    $display("test software reset done");
  endtask
  task automatic conclude;
    $display("checks run %0d, failed %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***********************************************************
  // clock, watchdog, main sequence
  // ***********************************************************
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    conclude();
  end
  initial begin
    miscompares = 0; tests_run = 0; rst = 1; ce = 1; s_axi_wstrb = 4'hF;
    s_axi_awaddr = 8'h0; s_axi_awvalid = 0; s_axi_wdata = 32'h0; s_axi_wvalid = 0;
    s_axi_bready = 0; s_axi_araddr = 8'h0; s_axi_arvalid = 0; s_axi_rready = 0;
    want_events = 13'h0; want_supply = 0; present_route_masks = 13'h0;
    repeat (8) @(posedge clock);
    rst <= 0;
    t_reset();
    t_standby();
    t_present();
    t_soft();
    conclude();
  end
endmodule
`default_nettype wire
